// ### crf_defs.vh
// constants for the cpu register file: widths, register indices, flag positions
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
`define CRF_AW 4
`define CRF_DW 32
// register indices on the software port
`define CRF_IDX_DR0 4'h0
`define CRF_IDX_DR1 4'h1
`define CRF_IDX_DR2 4'h2
`define CRF_IDX_DR3 4'h3
`define CRF_IDX_PTRL 4'h4
`define CRF_IDX_PTRH 4'h5
`define CRF_IDX_FB 4'h6
`define CRF_IDX_VTB 4'h7
`define CRF_IDX_PC 4'h8
`define CRF_IDX_USP 4'h9
`define CRF_IDX_ISP 4'hA
`define CRF_IDX_SB 4'hB
`define CRF_IDX_FLG 4'hC
`define CRF_IDX_WEVEN 4'hD
`define CRF_IDX_WODD 4'hE
`define CRF_IDX_WPTR 4'hF
// flag bit positions
`define CRF_F_C 0
`define CRF_F_D 1
`define CRF_F_Z 2
`define CRF_F_S 3
`define CRF_F_B 4
`define CRF_F_O 5
`define CRF_F_U 7
`define CRF_FLG_W 11
`define CRF_FLG_MASK 11'h7FF
// byte-lane select for data register access
`define CRF_LANE_FULL 2'h0
`define CRF_LANE_LOW 2'h1
`define CRF_LANE_HIGH 2'h2
// alu operand width
`define CRF_ALU_W16 1'b0
`define CRF_ALU_W8 1'b1
`define CRF_ZERO16 16'h0000
`define CRF_ZERO20 20'h00000
`define CRF_ZERO11 11'h000
`define CRF_ZERO32 32'h00000000
// top bit of the 20-bit address registers in wdata
`define CRF_W20_MSB 19
`endif

// ### crf_regfile.v
// cpu register file: two banks of data, pointer and frame base registers plus shared registers and flags
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "crf_defs.vh"
//
// Behaviour
// - thirteen registers; data, pointer and frame base registers duplicated in two banks.
// - data registers 16 bits; first two also accessible as 8-bit halves.
// - third:first and fourth:second data registers form 32-bit registers.
// - two 16-bit pointer registers, usable as addresses and as operands.
// - second pointer above first forms one 32-bit pointer.
// - frame base register 16 bits, base for frame-relative addressing.
// - vector table base register 20 bits, start of interrupt vectors.
// - program counter 20 bits, address of next instruction.
// - user and interrupt stack pointers 16 bits; stack flag picks active one.
// - static base register 16 bits, base for static-relative addressing.
// - flag register 11 bits holding carry, debug, zero, sign, bank, overflow, stack flags.
// - carry flag takes carry, borrow or shifted-out bit of every alu operation.
// - zero flag set when the result is zero, else cleared.
// - sign flag set when the result is negative, else cleared.
// - bank flag 0 picks bank 0, 1 picks bank 1, for banked accesses.
// - overflow flag set when the operation overflows, else cleared.
//
// Software index map on addr:
//   0 to 3: data registers of the selected bank
//   4: low pointer register of the selected bank
//   5: high pointer register of the selected bank
//   6: frame base of the selected bank
//   7: vector table base, 20 bits in wdata bits 19 to 0
//   8: program counter, 20 bits
//   9: user stack pointer
//   10: interrupt stack pointer
//   11: static base
//   12: flag register, 11 bits
//   13: wide view, third data register above the first
//   14: wide view, fourth data register above the second
//   15: wide view, high pointer above low pointer
// Lane codes, honoured on data registers 0 and 1 only:
//   0: full word in bits 15 to 0
//   1: low byte, carried in bits 7 to 0
//   2: high byte, also carried in bits 7 to 0
//   3: treated as a full word
// Flag register bits:
//   0: carry
//   1: debug, stored as written
//   2: zero
//   3: sign
//   4: bank select
//   5: overflow
//   6 and 8 to 10: plain storage, no effect
//   7: stack select, set picks the interrupt stack pointer
// Timing:
//   a write lands on the enabled edge that samples wr
//   a read answer stands on rdata for one cycle, then returns to zero
//   a read right after a write to the same index sees the new value
//   every view output lags its stored value by one enabled cycle
//   ce low freezes every register, view and rdata
// Limitations:
//   keeping the debug flag at zero is left to the core
//   byte-wide alu results flag zero and sign from the low byte only
//   a pc advance beats a software pc write in the same cycle
module crf_regfile (
    input wire clk,
    input wire nrst,
    input wire ce,
    // software register port
    input wire [3:0] addr,
    input wire [1:0] lane,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // alu flag update from the execution unit
    input wire alu_upd,
    input wire alu_width,
    input wire [15:0] alu_result,
    input wire alu_carry,
    input wire alu_ovf,
    // program counter advance from the execution unit
    input wire pc_load,
    input wire [19:0] pc_next_in,
    // live views for the address generation logic
    output reg [19:0] pc_out,
    output reg [15:0] active_sp,
    output reg [15:0] frame_base_out,
    output reg [15:0] static_base_out,
    output reg [19:0] vector_base_out,
    output reg [31:0] wide_pointer_pair,
    output reg [10:0] flags_out
);

    // banked storage, index [bank*4 + n] for data, [bank*2 + n] for pointers, [bank] for frame base
    reg [15:0] data_reg [0:7];
    reg [15:0] ptr_reg [0:3];
    reg [15:0] frame_base [0:1];
    reg [19:0] vector_table_base;
    reg [19:0] program_counter;
    reg [15:0] user_stack_pointer;
    reg [15:0] irq_stack_pointer;
    reg [15:0] static_base;
    reg [10:0] cpu_state_flags;

    wire bank;
    wire stk;
    wire [2:0] b4;
    wire [1:0] b2;
    wire [15:0] dlo;
    wire [15:0] dhi;
    reg [10:0] next_flags;
    reg res_zero;
    reg res_neg;
    reg [31:0] next_rdata;
    reg [10:0] sw_flags;
    reg [15:0] next_sp;
    wire [31:0] wide_ptr_now;
    wire wr_en;
    wire lane_low;
    wire lane_high;
    wire wr_vtb;
    wire wr_pc;
    wire wr_usp;
    wire wr_isp;
    wire wr_sb;
    wire wr_flg;

    assign bank = cpu_state_flags[`CRF_F_B];
    assign stk = cpu_state_flags[`CRF_F_U];
    assign b4 = {bank, 2'b00};
    assign b2 = {bank, 1'b0};
    assign dlo = wdata[15:0];
    assign dhi = wdata[31:16];
    assign wide_ptr_now = {ptr_reg[b2 + 2'h1], ptr_reg[b2]};

    // strobe decode; ce is folded in so a frozen core drops every write
    assign wr_en = ce && wr;
    assign lane_low = (lane == `CRF_LANE_LOW);
    assign lane_high = (lane == `CRF_LANE_HIGH);
    assign wr_vtb = wr_en && (addr == `CRF_IDX_VTB);
    assign wr_pc = wr_en && (addr == `CRF_IDX_PC);
    assign wr_usp = wr_en && (addr == `CRF_IDX_USP);
    assign wr_isp = wr_en && (addr == `CRF_IDX_ISP);
    assign wr_sb = wr_en && (addr == `CRF_IDX_SB);
    assign wr_flg = wr_en && (addr == `CRF_IDX_FLG);

    // result tests depend on operand width so byte ops flag from bit 7
    always @* begin
        if (alu_width == `CRF_ALU_W8) begin
            res_zero = (alu_result[7:0] == 8'h00);
            res_neg = alu_result[7];
        end else begin
            res_zero = (alu_result == `CRF_ZERO16);
            res_neg = alu_result[15];
        end
    end

    // software stage: a flag write replaces the whole register, debug bit included
    always @* begin
        sw_flags = cpu_state_flags;
        if (wr_flg) begin
            sw_flags = wdata[`CRF_FLG_W-1:0] & `CRF_FLG_MASK;
        end
    end

    // alu stage: arithmetic flags override a same-cycle write, the other bits keep it
    always @* begin
        next_flags = sw_flags;
        if (alu_upd) begin
            next_flags[`CRF_F_C] = alu_carry;
            next_flags[`CRF_F_Z] = res_zero;
            next_flags[`CRF_F_S] = res_neg;
            next_flags[`CRF_F_O] = alu_ovf;
        end
    end

    // banked data registers: one generate lane per register index
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_dreg
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    data_reg[g] <= `CRF_ZERO16;
                end else if (ce && wr && (g / 4) == bank) begin
                    if (addr == (g % 4)) begin
                        if (lane_low && (g % 4) < 2) begin
                            data_reg[g][7:0] <= wdata[7:0];
                        end else if (lane_high && (g % 4) < 2) begin
                            data_reg[g][15:8] <= wdata[7:0];
                        end else begin
                            data_reg[g] <= dlo;
                        end
                    end else if (addr == `CRF_IDX_WEVEN && (g % 2) == 0) begin
                        data_reg[g] <= ((g % 4) == 0) ? dlo : dhi;
                    end else if (addr == `CRF_IDX_WODD && (g % 2) == 1) begin
                        data_reg[g] <= ((g % 4) == 1) ? dlo : dhi;
                    end
                end
            end
        end
        for (g = 0; g < 4; g = g + 1) begin : gen_preg
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ptr_reg[g] <= `CRF_ZERO16;
                end else if (ce && wr && (g / 2) == bank) begin
                    if (addr == `CRF_IDX_PTRL + (g % 2)) begin
                        ptr_reg[g] <= dlo;
                    end else if (addr == `CRF_IDX_WPTR) begin
                        ptr_reg[g] <= ((g % 2) == 0) ? dlo : dhi;
                    end
                end
            end
        end
        for (g = 0; g < 2; g = g + 1) begin : gen_fb
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    frame_base[g] <= `CRF_ZERO16;
                end else if (ce && wr && g == bank && addr == `CRF_IDX_FB) begin
                    frame_base[g] <= dlo;
                end
            end
        end
    endgenerate

    // vector table base: only software moves it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vector_table_base <= `CRF_ZERO20;
        end else if (wr_vtb) begin
            vector_table_base <= wdata[`CRF_W20_MSB:0];
        end
    end

    // program counter: an advance from execution wins, so a stray software write cannot skip code
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            program_counter <= `CRF_ZERO20;
        end else if (ce && pc_load) begin
            program_counter <= pc_next_in;
        end else if (wr_pc) begin
            program_counter <= wdata[`CRF_W20_MSB:0];
        end
    end

    // user stack pointer, writable whichever pointer is active
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            user_stack_pointer <= `CRF_ZERO16;
        end else if (wr_usp) begin
            user_stack_pointer <= dlo;
        end
    end

    // interrupt stack pointer, writable whichever pointer is active
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stack_pointer <= `CRF_ZERO16;
        end else if (wr_isp) begin
            irq_stack_pointer <= dlo;
        end
    end

    // static base
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            static_base <= `CRF_ZERO16;
        end else if (wr_sb) begin
            static_base <= dlo;
        end
    end

    // flag register takes its next value on every enabled edge, so alu reports need no strobe
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_state_flags <= `CRF_ZERO11;
        end else if (ce) begin
            cpu_state_flags <= next_flags;
        end
    end

    // read mux over the selected bank
    always @* begin
        next_rdata = `CRF_ZERO32;
        case (addr)
            `CRF_IDX_DR0, `CRF_IDX_DR1: begin
                if (lane_low) begin
                    next_rdata = {24'h000000, data_reg[b4 + {1'b0, addr[1:0]}][7:0]};
                end else if (lane_high) begin
                    next_rdata = {24'h000000, data_reg[b4 + {1'b0, addr[1:0]}][15:8]};
                end else begin
                    next_rdata = {16'h0000, data_reg[b4 + {1'b0, addr[1:0]}]};
                end
            end
            `CRF_IDX_DR2, `CRF_IDX_DR3: next_rdata = {16'h0000, data_reg[b4 + {1'b0, addr[1:0]}]};
            `CRF_IDX_PTRL: next_rdata = {16'h0000, ptr_reg[b2]};
            `CRF_IDX_PTRH: next_rdata = {16'h0000, ptr_reg[b2 + 2'h1]};
            `CRF_IDX_FB: next_rdata = {16'h0000, frame_base[bank]};
            `CRF_IDX_VTB: next_rdata = {12'h000, vector_table_base};
            `CRF_IDX_PC: next_rdata = {12'h000, program_counter};
            `CRF_IDX_USP: next_rdata = {16'h0000, user_stack_pointer};
            `CRF_IDX_ISP: next_rdata = {16'h0000, irq_stack_pointer};
            `CRF_IDX_SB: next_rdata = {16'h0000, static_base};
            `CRF_IDX_FLG: next_rdata = {21'h000000, cpu_state_flags};
            `CRF_IDX_WEVEN: next_rdata = {data_reg[b4 + 3'h2], data_reg[b4]};
            `CRF_IDX_WODD: next_rdata = {data_reg[b4 + 3'h3], data_reg[b4 + 3'h1]};
            `CRF_IDX_WPTR: next_rdata = wide_ptr_now;
            default: next_rdata = `CRF_ZERO32;
        endcase
    end

    // active stack pointer select, kept apart so the view and any later consumer agree
    always @* begin
        next_sp = stk ? irq_stack_pointer : user_stack_pointer;
    end

    // read data: a one-cycle answer, zero after any enabled edge with no read, so stale words linger only while ce is low
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= `CRF_ZERO32;
        end else if (ce) begin
            rdata <= rd ? next_rdata : `CRF_ZERO32;
        end
    end

    // shared views for address generation, one enabled cycle behind the stored values
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_out <= `CRF_ZERO20;
            static_base_out <= `CRF_ZERO16;
            vector_base_out <= `CRF_ZERO20;
        end else if (ce) begin
            pc_out <= program_counter;
            static_base_out <= static_base;
            vector_base_out <= vector_table_base;
        end
    end

    // stack view; registered, so the pointer switch shows one cycle after the flag write
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_sp <= `CRF_ZERO16;
        end else if (ce) begin
            active_sp <= next_sp;
        end
    end

    // banked views follow the bank flag, so they too switch one cycle after it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_base_out <= `CRF_ZERO16;
            wide_pointer_pair <= `CRF_ZERO32;
        end else if (ce) begin
            frame_base_out <= frame_base[bank];
            wide_pointer_pair <= wide_ptr_now;
        end
    end

    // flag view for the execution unit's condition tests
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_out <= `CRF_ZERO11;
        end else if (ce) begin
            flags_out <= cpu_state_flags;
        end
    end

endmodule

// ### crf_regfile_asserts.sv
// port assertions for the cpu register file
`timescale 1ns/1ps
module crf_regfile_asserts (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire rd,
    input wire wr,
    input wire [31:0] rdata,
    input wire alu_upd,
    input wire alu_width,
    input wire [15:0] alu_result,
    input wire alu_carry,
    input wire alu_ovf,
    input wire [10:0] flags_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // report taken, then one more enabled edge before the flag view shows it
    sequence s_alu;
        ce && alu_upd ##1 ce;
    endsequence
    a_read_idle: assert property (ce && !rd |=> rdata == 32'h0) else $error("rdata idle");
    a_read_hold: assert property (!ce |=> $stable(rdata)) else $error("rdata moved");
    a_view_hold: assert property (!ce |=> $stable(flags_out)) else $error("flags moved");
    a_flags_steady: assert property (ce && !wr && !alu_upd |=> ##1 $stable(flags_out)) else $error("flags");
    a_carry_flag: assert property (s_alu |=> flags_out[0] == $past(alu_carry, 2)) else $error("carry");
    a_ovf_flag: assert property (s_alu |=> flags_out[5] == $past(alu_ovf, 2)) else $error("overflow");
    a_zero_flag: assert property (s_alu |=> flags_out[2] ==
        ($past(alu_width, 2) ? $past(alu_result[7:0], 2) == 8'h0 : $past(alu_result, 2) == 16'h0)) else $error("zero");
    a_sign_flag: assert property (s_alu |=> flags_out[3] ==
        ($past(alu_width, 2) ? $past(alu_result[7], 2) : $past(alu_result[15], 2))) else $error("sign");
endmodule
bind crf_regfile crf_regfile_asserts crf_regfile_asserts_inst (.clk(clk), .nrst(nrst), .ce(ce), .rd(rd), .wr(wr),
    .rdata(rdata), .alu_upd(alu_upd), .alu_width(alu_width), .alu_result(alu_result), .alu_carry(alu_carry),
    .alu_ovf(alu_ovf), .flags_out(flags_out));

// ### crf_alu_model.sv
// adder stand-in for the execution unit that reports results
`timescale 1ns/1ps
module crf_alu_model (
    input wire clk,
    input wire go,
    input wire wid,
    input wire [15:0] a,
    input wire [15:0] b,
    output reg alu_upd = 1'h0,
    output reg alu_width,
    output reg [15:0] alu_result,
    output reg alu_carry,
    output reg alu_ovf
);
    reg [15:0] p;
    reg [15:0] q;
    reg [16:0] s;
    // byte ops run in the top lane so one adder gives carry and overflow
    always @(posedge clk) begin
        p = wid ? {a[7:0], 8'h00} : a;
        q = wid ? {b[7:0], 8'h00} : b;
        s = {1'h0, p} + {1'h0, q};
        alu_upd <= go;
        alu_width <= wid;
        // outside the report the lines toggle, so a late sample reads junk
        alu_result <= go ? (wid ? {8'hFF, s[15:8]} : s[15:0]) : ~alu_result;
        alu_carry <= go ? s[16] : ~alu_carry;
        alu_ovf <= go ? (p[15] == q[15]) && (s[15] != p[15]) : ~alu_ovf;
    end
endmodule

// ### crf_regfile_bench.sv
// self-checking bench for the cpu register file
`timescale 1ns/1ps
module crf_regfile_bench;
    reg clk = 1'h0, nrst = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0, go = 1'h0, wid = 1'h0, pc_load = 1'h0;
    reg [3:0] addr = 4'h0;
    reg [1:0] lane = 2'h0;
    reg [31:0] wdata = 32'h0;
    reg [19:0] pc_next_in = 20'h0;
    reg [15:0] a = 16'h0, b = 16'h0;
    wire alu_upd, alu_width, alu_carry, alu_ovf;
    wire [15:0] alu_result, active_sp, frame_base_out, static_base_out;
    wire [19:0] pc_out, vector_base_out;
    wire [31:0] rdata, wide_pointer_pair;
    wire [10:0] flags_out;
    integer err_total = 0, samples_checked = 0, cyc = 0, i;
    initial forever #20 clk = ~clk;
    crf_regfile crf_regfile_inst (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .lane(lane), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .alu_upd(alu_upd), .alu_width(alu_width), .alu_result(alu_result),
        .alu_carry(alu_carry), .alu_ovf(alu_ovf), .pc_load(pc_load), .pc_next_in(pc_next_in), .pc_out(pc_out),
        .active_sp(active_sp), .frame_base_out(frame_base_out), .static_base_out(static_base_out),
        .vector_base_out(vector_base_out),
        .wide_pointer_pair(wide_pointer_pair), .flags_out(flags_out));
    crf_alu_model crf_alu_model_inst (.clk(clk), .go(go), .wid(wid), .a(a), .b(b), .alu_upd(alu_upd),
        .alu_width(alu_width), .alu_result(alu_result), .alu_carry(alu_carry), .alu_ovf(alu_ovf));
    task check(input string what, input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one strobe cycle; on a read d is the expected value, sampled in the only cycle it stands
    task acc(input w, input [3:0] ad, input [1:0] ln, input [31:0] d);
        @(posedge clk);
        addr <= ad;
        lane <= ln;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
        if (!w)
            #1 check($sformatf("reg %h", ad), rdata, d);
    endtask
    // one alu report, then read back the flag register
    task alu(input w, input [15:0] x, input [15:0] y, input [31:0] f);
        @(posedge clk);
        wid <= w;
        a <= x;
        b <= y;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        acc(0, 4'hC, 2'h0, f);
    endtask
    task give_verdict;
        $display("checked %0d mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // a hung run ends here; the tests need well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        for (i = 0; i < 16; i = i + 1)
            acc(0, i[3:0], 2'h0, 32'h0);
        for (i = 0; i < 12; i = i + 1)
            acc(1, i[3:0], 2'h0, 32'hFFFFFFFF);
        for (i = 0; i < 12; i = i + 1)
            acc(0, i[3:0], 2'h0, (i == 7 || i == 8) ? 32'hFFFFF : 32'hFFFF);
        check("frame view", frame_base_out, 32'hFFFF);
        check("static view", static_base_out, 32'hFFFF);
        check("vector view", vector_base_out, 32'hFFFFF);
        acc(1, 4'hA, 2'h0, 32'h0ABC);
        acc(1, 4'hC, 2'h0, 32'hFFFD);
        acc(0, 4'hC, 2'h0, 32'h7FD);
        check("stack view", active_sp, 32'h0ABC);
        check("frame view", frame_base_out, 32'h0);
        acc(0, 4'h0, 2'h0, 32'h0);
        acc(1, 4'h0, 2'h0, 32'h00AA);
        acc(1, 4'hC, 2'h0, 32'h0);
        acc(0, 4'h0, 2'h0, 32'hFFFF);
        check("stack view", active_sp, 32'hFFFF);
        check("frame view", frame_base_out, 32'hFFFF);
        $display("test registers done");
        acc(1, 4'h0, 2'h1, 32'h3C);
        acc(0, 4'h0, 2'h0, 32'hFF3C);
        acc(0, 4'h0, 2'h2, 32'hFF);
        acc(1, 4'h1, 2'h2, 32'hA5);
        acc(0, 4'h1, 2'h0, 32'hA5FF);
        acc(0, 4'h1, 2'h1, 32'hFF);
        acc(1, 4'hD, 2'h0, 32'h12345678);
        acc(0, 4'h2, 2'h0, 32'h1234);
        acc(1, 4'hE, 2'h0, 32'h9ABCDEF0);
        acc(0, 4'hE, 2'h0, 32'h9ABCDEF0);
        acc(1, 4'hF, 2'h0, 32'h4E2D0123);
        acc(0, 4'h5, 2'h0, 32'h4E2D);
        check("pointer view", wide_pointer_pair, 32'h4E2D0123);
        $display("test views done");
        alu(0, 16'hFFFF, 16'h0001, 32'h005);
        alu(0, 16'h7FFF, 16'h0001, 32'h028);
        alu(0, 16'h0003, 16'h0004, 32'h000);
        alu(1, 16'h12FF, 16'h3401, 32'h005);
        alu(1, 16'h0040, 16'h0040, 32'h028);
        $display("test alu done");
        // a software pc write beside an advance must lose to the advance
        @(posedge clk);
        pc_load <= 1'h1;
        pc_next_in <= 20'hABCDE;
        addr <= 4'h8;
        wdata <= 32'h12345;
        wr <= 1'h1;
        @(posedge clk);
        pc_load <= 1'h0;
        wr <= 1'h0;
        acc(0, 4'h8, 2'h0, 32'hABCDE);
        check("pc view", pc_out, 32'hABCDE);
        @(posedge clk);
        ce <= 1'h0;
        acc(1, 4'hB, 2'h0, 32'h7777);
        ce <= 1'h1;
        acc(0, 4'hB, 2'h0, 32'hFFFF);
        $display("test pc and enable done");
        give_verdict;
    end
endmodule
